//--- rtl/fwpg_regs.svh
`ifndef FWPG_REGS_SVH
`define FWPG_REGS_SVH

// Register addresses on the plain port
`define FWPG_ADDR_W          4
`define FWPG_OFF_CTRL_ONE    4'h0
`define FWPG_OFF_CTRL_TWO    4'h1
`define FWPG_OFF_STATUS      4'h2

// Control register one field positions
`define FWPG_BIT_PROG        0
`define FWPG_BIT_ERASE       1
`define FWPG_BIT_PROG_SETUP  2
`define FWPG_BIT_ERASE_SETUP 3
`define FWPG_BIT_PROG_VERIFY 4
`define FWPG_BIT_ERASE_VER   5
`define FWPG_BIT_SW_WE       6
`define FWPG_BIT_PIN_WE      7

// Control register two field positions
`define FWPG_BIT_FLASH_ERR   7

// Reset values
`define FWPG_RST_CTRL_ONE    8'h00
`define FWPG_RST_CTRL_TWO    8'h00

// Writable bits of control register one
`define FWPG_CTRL_ONE_WMASK  8'h7f

`endif

//--- rtl/fwpg_pkg.sv
package fwpg_pkg;

  typedef enum logic [2:0] {
    FWPG_PROTECT = 3'b001,
    FWPG_ARMED   = 3'b010,
    FWPG_ACTIVE  = 3'b100
  } fwpg_state_e;

  typedef struct packed {
    logic prog;
    logic erase;
    logic prog_setup;
    logic erase_setup;
    logic prog_verify;
    logic erase_verify;
    logic sw_we;
  } fwpg_flash_ctrl_s;

endpackage : fwpg_pkg

//--- rtl/fwpg_gate.sv
`include "fwpg_regs.svh"

module fwpg_gate (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Write-enable pin from the system controller
  input  wire logic                       flash_write_enable_pin,
  // Register port
  input  wire logic [`FWPG_ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  // Gated controls toward the flash array
  output fwpg_pkg::fwpg_flash_ctrl_s      flash_ctrl,
  output logic                            flash_protected,
  output logic                            flash_rewrite_ok
);

  logic                        pin_meta;
  logic                        pin_sync;
  logic [7:0]                  ctrl_one;
  logic [7:0]                  next_ctrl_one;
  logic [7:0]                  ctrl_two;
  logic [7:0]                  next_ctrl_two;
  logic [7:0]                  next_rdata;
  fwpg_pkg::fwpg_state_e       state;
  fwpg_pkg::fwpg_state_e       next_state;
  fwpg_pkg::fwpg_flash_ctrl_s  next_flash_ctrl;
  logic                        bad_release;

  // Pin may change at any moment, so it is synchronised first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= flash_write_enable_pin;
      pin_sync <= pin_meta;
    end
  end

  // Releasing the pin in the active state with any control bit still set is logged
  assign bad_release = (state == fwpg_pkg::FWPG_ACTIVE) && !pin_sync
                       && (ctrl_one[6:0] != 7'h00);

  always_comb begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    if (reg_wr && reg_addr == `FWPG_OFF_CTRL_ONE) begin
      // Pin status position is never written
      next_ctrl_one = reg_wdata & `FWPG_CTRL_ONE_WMASK;
    end
    if (reg_wr && reg_addr == `FWPG_OFF_CTRL_TWO) begin
      // Writing one clears the sticky error flag
      if (reg_wdata[`FWPG_BIT_FLASH_ERR]) begin
        next_ctrl_two[`FWPG_BIT_FLASH_ERR] = 1'b0;
      end
    end
    // Pin low wipes every control bit, software cannot hold them
    if (!pin_sync) begin
      next_ctrl_one = `FWPG_RST_CTRL_ONE;
    end
    // Set wins over a clear in the same cycle
    if (bad_release) begin
      next_ctrl_two[`FWPG_BIT_FLASH_ERR] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `FWPG_OFF_CTRL_ONE: begin
          next_rdata = {pin_sync, ctrl_one[6:0]};
        end
        `FWPG_OFF_CTRL_TWO: begin
          next_rdata = ctrl_two;
        end
        `FWPG_OFF_STATUS: begin
          next_rdata = {5'h00, state};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      fwpg_pkg::FWPG_PROTECT: begin
        if (pin_sync) begin
          next_state = fwpg_pkg::FWPG_ARMED;
        end
      end
      fwpg_pkg::FWPG_ARMED: begin
        if (!pin_sync) begin
          next_state = fwpg_pkg::FWPG_PROTECT;
        end else if (ctrl_one[`FWPG_BIT_SW_WE]) begin
          next_state = fwpg_pkg::FWPG_ACTIVE;
        end
      end
      fwpg_pkg::FWPG_ACTIVE: begin
        if (!pin_sync) begin
          next_state = fwpg_pkg::FWPG_PROTECT;
        end else if (!ctrl_one[`FWPG_BIT_SW_WE]) begin
          next_state = fwpg_pkg::FWPG_ARMED;
        end
      end
      default: begin
        next_state = fwpg_pkg::FWPG_PROTECT;
      end
    endcase
  end

  // Array controls pass only while pin high and software enabled
  always_comb begin
    next_flash_ctrl = '0;
    if (pin_sync && ctrl_one[`FWPG_BIT_SW_WE]) begin
      next_flash_ctrl.prog         = ctrl_one[`FWPG_BIT_PROG];
      next_flash_ctrl.erase        = ctrl_one[`FWPG_BIT_ERASE];
      next_flash_ctrl.prog_setup   = ctrl_one[`FWPG_BIT_PROG_SETUP];
      next_flash_ctrl.erase_setup  = ctrl_one[`FWPG_BIT_ERASE_SETUP];
      next_flash_ctrl.prog_verify  = ctrl_one[`FWPG_BIT_PROG_VERIFY];
      next_flash_ctrl.erase_verify = ctrl_one[`FWPG_BIT_ERASE_VER];
      next_flash_ctrl.sw_we        = 1'b1;
    end
    // Synchronised pin low overrides everything, taking effect at the next clock edge
    if (!pin_sync) begin
      next_flash_ctrl = '0;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one <= `FWPG_RST_CTRL_ONE;
      ctrl_two <= `FWPG_RST_CTRL_TWO;
    end else begin
      ctrl_one <= next_ctrl_one;
      ctrl_two <= next_ctrl_two;
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Protection state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fwpg_pkg::FWPG_PROTECT;
    end else begin
      state <= next_state;
    end
  end

  // Gated array controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ctrl <= '0;
    end else begin
      flash_ctrl <= next_flash_ctrl;
    end
  end

  assign flash_protected  = (state == fwpg_pkg::FWPG_PROTECT);
  assign flash_rewrite_ok = flash_ctrl.sw_we;

endmodule : fwpg_gate

//--- testbench/fwpg_props.sv
`include "fwpg_regs.svh"
module fwpg_props (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  // Pin and register port
  input wire logic                     flash_write_enable_pin,
  input wire logic [`FWPG_ADDR_W-1:0]  reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_rdata,
  // Array side
  input wire fwpg_pkg::fwpg_flash_ctrl_s flash_ctrl,
  input wire logic                     flash_protected,
  input wire logic                     flash_rewrite_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire pin = flash_write_enable_pin;
  property p_prot;
    !pin [*5] |-> flash_ctrl == '0 && flash_protected;
  endproperty
  a_prot: assert property (p_prot) else $error("gate open");
  // Sync delay lets controls outlive the pin by up to three cycles
  property p_gate;
    |flash_ctrl |-> $past(pin, 3);
  endproperty
  a_gate: assert property (p_gate) else $error("ctrl early");
  property p_stat;
    reg_rd && reg_addr == 4'h0 && $stable(pin) && pin == $past(pin, 2)
      |=> reg_rdata[7] == $past(pin);
  endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_rew;
    pin [*6] ##0 (reg_wr && reg_addr == 4'h0 && reg_wdata[6]) ##1 pin [*3]
      |-> flash_rewrite_ok && flash_ctrl.sw_we;
  endproperty
  a_rew: assert property (p_rew) else $error("no rewrite");
  property p_user;
    $rose(pin) ##0 pin [*6] |-> !flash_protected;
  endproperty
  a_user: assert property (p_user) else $error("pin ignored");
  c_rew: cover property (flash_rewrite_ok);
  c_drop: cover property ($fell(pin));
  c_rd: cover property (reg_rd && reg_addr == 4'h0 && pin);
endmodule : fwpg_props
bind fwpg_gate fwpg_props i_props (.*);

//--- testbench/fwpg_ctl_model.sv
module fwpg_ctl_model #(parameter int OSC_CYC = 20) (
  // Clock, reset and job request
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic job,
  input  wire logic busy,
  // Pin toward the device
  output logic      flash_write_enable_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int   osc = 0;
  logic q   = 1'b0;
  assign flash_write_enable_pin = q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc <= 0;
      q   <= 1'b0;
    end else if (osc < OSC_CYC)
      osc <= osc + 1;
    else if (job)
      q <= 1'b1;
    else if (!busy)
      q <= 1'b0;
  end
endmodule : fwpg_ctl_model

//--- testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, job = 0;
  logic flash_write_enable_pin, flash_protected, flash_rewrite_ok;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  fwpg_pkg::fwpg_flash_ctrl_s flash_ctrl;
  int fail_count = 0, n_tests = 0;
  always #25 clk = ~clk;
  fwpg_gate i_dut (.*);
  fwpg_ctl_model i_ctl (.clk(clk), .rst_n(rst_n), .job(job),
    .busy(|flash_ctrl), .flash_write_enable_pin(flash_write_enable_pin));
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [7:0] e, s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // Bounded wait, then room for the two-flop pin sync
  task automatic wpin(input logic v);
    for (int i = 0; i < 60 && flash_write_enable_pin !== v; i++)
      @(posedge clk);
    if (flash_write_enable_pin !== v) begin
      fail_count++;
      give_verdict();
    end
    repeat (4) @(posedge clk);
  endtask : wpin
  task automatic t_idle;
    chk("protected", 8'h01, {7'h00, flash_protected});
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h00);
    chk("flash_ctrl", 8'h00, {1'b0, flash_ctrl});
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h01);
    rd(4'h3, 8'h00);
  endtask : t_idle
  task automatic t_job;
    @(posedge clk);
    job <= 1'b1;
    wpin(1'b1);
    rd(4'h0, 8'h80);
    wr(4'h0, 8'h41);
    rd(4'h0, 8'hc1);
    chk("rewrite_ok", 8'h01, {7'h00, flash_rewrite_ok});
    chk("flash_ctrl", 8'h41, {1'b0, flash_ctrl});
    rd(4'h2, 8'h04);
    wr(4'h0, 8'h00);
    job <= 1'b0;
    wpin(1'b0);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h01);
  endtask : t_job
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_idle();
    repeat (2) t_job();
    give_verdict();
  end
endmodule : testbench
